// File: common/idfw_pkg.sv
// Package: word numbers, fixed bit layouts and register map of the identify feature words
package idfw_pkg;
   // AHB register byte offsets
   localparam logic [7:0] IDFW_OFF_CTRL   = 8'h00;
   localparam logic [7:0] IDFW_OFF_SECCFG = 8'h04;
   localparam logic [7:0] IDFW_OFF_MODE   = 8'h08;
   localparam logic [7:0] IDFW_OFF_EVENT  = 8'h0C;
   localparam logic [7:0] IDFW_OFF_RDSEL  = 8'h10;
   localparam logic [7:0] IDFW_OFF_RDATA  = 8'h14;
   // Identify word numbers served by this block
   localparam logic [7:0] IDFW_W53  = 8'd53;
   localparam logic [7:0] IDFW_W78  = 8'd78;
   localparam logic [7:0] IDFW_W79  = 8'd79;
   localparam logic [7:0] IDFW_W82  = 8'd82;
   localparam logic [7:0] IDFW_W83  = 8'd83;
   localparam logic [7:0] IDFW_W84  = 8'd84;
   localparam logic [7:0] IDFW_W85  = 8'd85;
   localparam logic [7:0] IDFW_W86  = 8'd86;
   localparam logic [7:0] IDFW_W87  = 8'd87;
   localparam logic [7:0] IDFW_W88  = 8'd88;
   localparam logic [7:0] IDFW_W89  = 8'd89;
   localparam logic [7:0] IDFW_W92  = 8'd92;
   localparam logic [7:0] IDFW_W128 = 8'd128;
   // Fixed parts of command-set words
   localparam logic [15:0] IDFW_CMDSET_FIXED = 16'h7008;  // bits 14,13,12,3
   localparam logic [15:0] IDFW_VALID_MARK   = 16'h4000;  // bit 14 one, bit 15 zero
   localparam logic [15:0] IDFW_W53_UDMA_OK  = 16'h0004;  // bit 2
   // Field positions
   localparam int IDFW_SECBIT   = 1;
   localparam int IDFW_WCBIT    = 5;
   localparam int IDFW_LABIT    = 6;
   localparam int IDFW_APMBIT   = 3;
   localparam int IDFW_LVLBIT   = 8;
   localparam int IDFW_UDSEL_LO = 8;
   // Reset values
   localparam logic [31:0] IDFW_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] IDFW_SECCFG_RST = 32'h0000_0000;
   localparam logic [31:0] IDFW_MODE_RST   = 32'h0000_0000;
endpackage : idfw_pkg

// File: rtl/idfw_words.sv
// Identify feature words 53 and 78..128 with an AHB-Lite slave for state and readback
`timescale 1ns/100ps
`default_nettype none
//
// Overview of operation
// - Word 78 reports six serial features supported
// - Word 79 reports which serial features enabled
// - Words 83/84 bit14 one, bit15 zero
// - Word 82 fixed ones and zeros
// - Word 82 security, write cache, look-ahead support
// - Word 83 zeros, bit3 advanced power support
// - Word 87 bit14 one, bit15 zero
// - Word 85 security, cache, look-ahead enabled
// - Word 85 fixed ones and zeros
// - Word 86 zeros, bit3 advanced power enabled
// - Word 88 one-hot selected Ultra DMA mode
// - Ultra and multiword DMA selection exclusive
// - Ultra DMA support bits are cumulative
// - Word 88 zero without Ultra DMA
// - Word 89 erase time in two-minute units
// - Word 92 master password revision code
// - Word 128 bit8 only at maximum level
// - Attempts expired sticks until hardware reset
// - Word 128 security status flags
// - Word 53 bit2 marks word 88 valid
module idfw_words #(
   parameter int UDMA_MAX_MODE = 6,
   parameter bit UDMA_SUPPORT  = 1'b1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  word_sel,
   output logic      [15:0] word_data,
   output logic             sec_cmd_abort,
   output logic             mdma_sel_clr
);
   import idfw_pkg::*;

   // Control registers
   logic [31:0] ctrl_q;
   logic [31:0] seccfg_q;
   logic [31:0] mode_q;
   logic        expired_q;
   logic [7:0]  rdsel_q;
   logic [15:0] word_data_q;
   logic [31:0] hrdata_q;
   logic        abort_q;
   logic        mclr_q;
   // Address phase capture
   logic        wr_pend_q;
   logic [7:0]  addr_q;

   // Turn a mode number into a one-hot field of seven; mode 7 gives zero
   function automatic logic [6:0] onehot7(input logic [2:0] m, input logic en);
      onehot7 = en ? 7'(7'h01 << m) : 7'h00;
   endfunction : onehot7

   // Cumulative support mask up to a top mode
   function automatic logic [6:0] cumul7(input int top);
      cumul7 = 7'((8'h02 << top) - 8'h01);
   endfunction : cumul7

   // Field decode of control registers
   // ctrl: [6:1] serial supported, [14:9] serial enabled, [16] wc sup, [17] la sup,
   //       [18] apm sup, [19] wc en, [20] la en, [21] apm en
   // seccfg: [0] sup, [1] enabled, [2] locked, [3] frozen, [4] max level,
   //         [5] enhanced erase, [23:8] erase time units
   // mode: [15:0] master revision, [18:16] udma mode, [19] udma sel, [20] mdma sel
   wire        sec_sup   = seccfg_q[0];
   wire        sec_en    = seccfg_q[1];
   wire        udma_req  = mode_q[19] & UDMA_SUPPORT;
   wire        mdma_req  = mode_q[20];
   wire        udma_on   = udma_req & ~mdma_req;  // Later mdma write clears udma
   wire [6:0]  udma_sel  = onehot7(mode_q[18:16], udma_on);
   wire [6:0]  udma_sup  = UDMA_SUPPORT ? cumul7(UDMA_MAX_MODE) : 7'h00;

   // Live words, rebuilt every cycle from current state
   wire [15:0] w53  = UDMA_SUPPORT ? IDFW_W53_UDMA_OK : 16'h0000;
   wire [15:0] w78  = {9'h000, ctrl_q[6:1], 1'b0};
   wire [15:0] w79  = {9'h000, ctrl_q[14:9] & ctrl_q[6:1], 1'b0};
   wire [15:0] w82  = IDFW_CMDSET_FIXED
                      | (16'(sec_sup) << IDFW_SECBIT)
                      | (16'(ctrl_q[16]) << IDFW_WCBIT)
                      | (16'(ctrl_q[17]) << IDFW_LABIT);
   wire [15:0] w83  = IDFW_VALID_MARK | (16'(ctrl_q[18]) << IDFW_APMBIT);
   wire [15:0] w84  = IDFW_VALID_MARK;
   wire [15:0] w85  = IDFW_CMDSET_FIXED
                      | (16'(sec_sup & sec_en) << IDFW_SECBIT)
                      | (16'(ctrl_q[19]) << IDFW_WCBIT)
                      | (16'(ctrl_q[20]) << IDFW_LABIT);
   wire [15:0] w86  = 16'(ctrl_q[21] & ctrl_q[18]) << IDFW_APMBIT;
   wire [15:0] w87  = IDFW_VALID_MARK;
   wire [15:0] w88  = UDMA_SUPPORT ? {1'b0, udma_sel, 1'b0, udma_sup} : 16'h0000;
   wire [15:0] w89  = sec_sup ? seccfg_q[23:8] : 16'h0000;
   wire [15:0] w92  = sec_sup ? mode_q[15:0] : 16'h0000;
   wire        lvl  = sec_sup & sec_en & seccfg_q[4];
   wire [15:0] w128 = sec_sup ? ((16'(lvl) << IDFW_LVLBIT)
                      | {10'h000, seccfg_q[5], expired_q, seccfg_q[3:1], 1'b1})
                      : 16'h0000;

   // Word selection for both the identify port and the bus readback
   function automatic logic [15:0] pick(input logic [7:0] n, input logic [15:0] a53,
         input logic [15:0] a78, input logic [15:0] a79, input logic [15:0] a82,
         input logic [15:0] a83, input logic [15:0] a84, input logic [15:0] a85,
         input logic [15:0] a86, input logic [15:0] a87, input logic [15:0] a88,
         input logic [15:0] a89, input logic [15:0] a92, input logic [15:0] a128);
      case (n)
         IDFW_W53:  pick = a53;
         IDFW_W78:  pick = a78;
         IDFW_W79:  pick = a79;
         IDFW_W82:  pick = a82;
         IDFW_W83:  pick = a83;
         IDFW_W84:  pick = a84;
         IDFW_W85:  pick = a85;
         IDFW_W86:  pick = a86;
         IDFW_W87:  pick = a87;
         IDFW_W88:  pick = a88;
         IDFW_W89:  pick = a89;
         IDFW_W92:  pick = a92;
         IDFW_W128: pick = a128;
         default:   pick = 16'h0000;
      endcase
   endfunction : pick

   wire [15:0] port_word = pick(word_sel, w53, w78, w79, w82, w83, w84, w85, w86, w87,
                                w88, w89, w92, w128);
   wire [15:0] bus_word  = pick(rdsel_q, w53, w78, w79, w82, w83, w84, w85, w86, w87,
                                w88, w89, w92, w128);

   // Bus decode; single-cycle slave, never waits
   wire        acc      = hsel & hready & htrans[1];
   wire        wr_ctrl  = wr_pend_q & (addr_q == IDFW_OFF_CTRL);
   wire        wr_sec   = wr_pend_q & (addr_q == IDFW_OFF_SECCFG);
   wire        wr_mode  = wr_pend_q & (addr_q == IDFW_OFF_MODE);
   wire        wr_evt   = wr_pend_q & (addr_q == IDFW_OFF_EVENT);
   wire        wr_rsel  = wr_pend_q & (addr_q == IDFW_OFF_RDSEL);
   // Expiry event from firmware; write-one on bit 0
   wire        expire_set = wr_evt & hwdata[0];
   // A new mode write with mdma set flags that the udma selection dropped
   wire        mdma_new   = wr_mode & hwdata[20];
   wire [7:0]  raddr      = haddr[7:0];

   // Read data mux for the address phase
   logic [31:0] rd_mux;
   always_comb begin
      case (raddr)
         IDFW_OFF_CTRL:   rd_mux = ctrl_q;
         IDFW_OFF_SECCFG: rd_mux = seccfg_q;
         IDFW_OFF_MODE:   rd_mux = mode_q;
         IDFW_OFF_EVENT:  rd_mux = {31'h0, expired_q};
         IDFW_OFF_RDSEL:  rd_mux = {24'h0, rdsel_q};
         IDFW_OFF_RDATA:  rd_mux = {16'h0, bus_word};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= acc & hwrite;
         addr_q    <= raddr;
      end
   end

   // Software-owned state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q   <= IDFW_CTRL_RST;
         seccfg_q <= IDFW_SECCFG_RST;
         mode_q   <= IDFW_MODE_RST;
         rdsel_q  <= 8'h00;
      end else begin
         if (wr_ctrl)
            ctrl_q <= hwdata;
         if (wr_sec)
            seccfg_q <= hwdata;
         if (wr_mode) begin
            // Selecting multiword DMA drops the Ultra DMA selection
            mode_q <= hwdata[20] ? {hwdata[31:20], 1'b0, hwdata[18:0]} : hwdata;
         end
         if (wr_rsel)
            rdsel_q <= hwdata[7:0];
      end
   end

   // Expired flag clears only on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         expired_q <= 1'b0;
      else if (expire_set & sec_sup)
         expired_q <= 1'b1;
   end

   // Registered outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         word_data_q <= 16'h0000;
         hrdata_q    <= 32'h0000_0000;
         abort_q     <= 1'b0;
         mclr_q      <= 1'b0;
      end else begin
         word_data_q <= port_word;
         if (acc & ~hwrite)
            hrdata_q <= rd_mux;
         abort_q     <= expired_q | (expire_set & sec_sup);
         mclr_q      <= mdma_new & mode_q[19];
      end
   end

   assign word_data     = word_data_q;
   assign hrdata        = hrdata_q;
   assign sec_cmd_abort = abort_q;
   assign mdma_sel_clr  = mclr_q;
   // Zero-wait slave, always OKAY
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
endmodule : idfw_words
`default_nettype wire

// File: tb/idfw_host.sv
// Host model: fetches identify words from the block
`timescale 1ns/100ps
`default_nettype none
module idfw_host (
   input  wire logic        hclk,
   output logic      [7:0]  word_sel,
   input  wire logic [15:0] word_data
);
   logic given;
   // Idle selection points at an unserved word
   initial word_sel = 8'h00;
   // Select, let the registered word land, then take it
   task automatic fetch(input logic [7:0] n, output logic [15:0] w);
      @(posedge hclk) word_sel <= n;
      repeat (2) @(posedge hclk);
      w = word_data;
      given = (w !== 16'h0000) && (w !== 16'hFFFF);
   endtask : fetch
endmodule : idfw_host
`default_nettype wire

// File: tb/idfw_words_properties.sv
// Checker: identify word layouts and status outputs
`timescale 1ns/100ps
`default_nettype none
module idfw_words_properties (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic [7:0]  word_sel,
   input wire logic [15:0] word_data,
   input wire logic        sec_cmd_abort,
   input wire logic        mdma_sel_clr
);
   logic [7:0] sel_q;
   logic       live_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Word number behind word_data; live_q hides the reset cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q  <= 8'h00;
         live_q <= 1'b0;
      end else begin
         sel_q  <= word_sel;
         live_q <= 1'b1;
      end
   end
   chk_w78_fixed:
      assert property (live_q && sel_q == 8'd78 |-> word_data[15:7] == 9'h0 && !word_data[0])
         else $error("w78 bad");
   chk_w79_fixed:
      assert property (live_q && sel_q == 8'd79 |-> word_data[15:7] == 9'h0 && !word_data[0])
         else $error("w79 bad");
   chk_w82_fixed:
      assert property (live_q && sel_q == 8'd82 |-> (word_data & 16'h779D) == 16'h7008)
         else $error("w82 bad");
   chk_w85_fixed:
      assert property (live_q && sel_q == 8'd85 |-> (word_data & 16'h779D) == 16'h7008)
         else $error("w85 bad");
   chk_w83_fixed:
      assert property (live_q && sel_q == 8'd83 |-> (word_data & 16'hC017) == 16'h4000)
         else $error("w83 bad");
   chk_valid_mark:
      assert property (live_q && (sel_q == 8'd84 || sel_q == 8'd87) |-> word_data[15:14] == 2'b01)
         else $error("mark bad");
   chk_w86_zero:
      assert property (live_q && sel_q == 8'd86 |-> (word_data & 16'h0017) == 16'h0000)
         else $error("w86 bad");
   chk_w88_shape:
      assert property (live_q && sel_q == 8'd88 |-> $onehot0(word_data[14:8]) && !word_data[15]
         && !word_data[7] && (word_data[6:0] & (word_data[6:0] + 7'h01)) == 7'h00)
         else $error("w88 bad");
   chk_w53_valid:
      assert property (live_q && sel_q == 8'd53 |-> word_data[2]) else $error("w53 bad");
   chk_w128_level:
      assert property (live_q && sel_q == 8'd128 && word_data[8] |-> word_data[1:0] == 2'b11)
         else $error("w128 bad");
   chk_abort_sticky:
      assert property (sec_cmd_abort |=> sec_cmd_abort) else $error("abort dropped");
   chk_clr_pulse:
      assert property (mdma_sel_clr |=> !mdma_sel_clr) else $error("clr not a pulse");
endmodule : idfw_words_properties
bind idfw_words idfw_words_properties u_props (.hclk(hclk), .hresetn(hresetn),
   .word_sel(word_sel), .word_data(word_data), .sec_cmd_abort(sec_cmd_abort),
   .mdma_sel_clr(mdma_sel_clr));
`default_nettype wire

// File: tb/tb_identify_feature_words.sv
// Testbench: register bus and identify word checks
`timescale 1ns/100ps
`default_nettype none
module tb_identify_feature_words;
   import idfw_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, abort, clr, clr_seen;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  word_sel;
   logic [15:0] word_data;
   int          failures, cmp_count;
   logic [7:0]  wn [12] = '{78, 79, 82, 83, 84, 85, 86, 87, 88, 89, 92, 128};
   idfw_words dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .word_sel(word_sel),
      .word_data(word_data), .sec_cmd_abort(abort), .mdma_sel_clr(clr));
   idfw_host host (.hclk(hclk), .word_sel(word_sel), .word_data(word_data));
   // 4 ns clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // The clear pulse lasts one cycle, so latch it
   always @(posedge hclk) if (clr === 1'b1) clr_seen <= 1'b1;
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", what, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   // Bounded wait for hready at a rising edge
   task automatic edge_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 64) begin
            failures++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask : edge_rdy
   // Single word transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      edge_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      edge_rdy();
      r = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk($sformatf("reg %h", a), e, r);
   endtask : rdchk
   task automatic wchk(input logic [7:0] n, input logic [15:0] e);
      logic [15:0] w;
      host.fetch(n, w);
      chk($sformatf("word %0d", n), {16'h0, e}, {16'h0, w});
   endtask : wchk
   task automatic all_w(input logic [15:0] e [12]);
      foreach (e[i]) wchk(wn[i], e[i]);
   endtask : all_w
   task automatic do_reset;
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask : do_reset
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, clr_seen, haddr, hwdata, htrans} = '0;
      hsize = 3'b010;
      failures = 0;
      cmp_count = 0;
      do_reset();
      rdchk(IDFW_OFF_CTRL, IDFW_CTRL_RST);
      rdchk(IDFW_OFF_MODE, IDFW_MODE_RST);
      rdchk(8'h20, 32'h0);
      wchk(IDFW_W53, 16'h0004);
      all_w('{16'h0000, 16'h0000, 16'h7008, 16'h4000, 16'h4000, 16'h7008,
              16'h0000, 16'h4000, 16'h007F, 16'h0000, 16'h0000, 16'h0000});
      wr(IDFW_OFF_CTRL, 32'h003F7E2A);
      all_w('{16'h002A, 16'h002A, 16'h7068, 16'h4008, 16'h4000, 16'h7068,
              16'h0008, 16'h4000, 16'h007F, 16'h0000, 16'h0000, 16'h0000});
      wr(IDFW_OFF_CTRL, 32'h0007147E);
      wr(IDFW_OFF_SECCFG, 32'h0001233F);
      wr(IDFW_OFF_MODE, 32'h0000FFFE);
      all_w('{16'h007E, 16'h0014, 16'h706A, 16'h4008, 16'h4000, 16'h700A,
              16'h0000, 16'h4000, 16'h007F, 16'h0123, 16'hFFFE, 16'h012F});
      wr(IDFW_OFF_SECCFG, 32'h0001232F);
      wchk(IDFW_W128, 16'h002F);
      wr(IDFW_OFF_EVENT, 32'h1);
      wchk(IDFW_W128, 16'h003F);
      chk("abort", 32'h1, {31'h0, abort});
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      wr(IDFW_OFF_EVENT, 32'h0);
      rdchk(IDFW_OFF_EVENT, 32'h1);
      for (int m = 0; m < 7; m++) begin
         wr(IDFW_OFF_MODE, 32'h0008FFFE | (32'(m) << 16));
         wchk(IDFW_W88, 16'h007F | (16'h1 << (8 + m)));
      end
      wr(IDFW_OFF_MODE, 32'h001EFFFE);
      wchk(IDFW_W88, 16'h007F);
      chk("clear pulse", 32'h1, {31'h0, clr_seen});
      rdchk(IDFW_OFF_MODE, 32'h0016FFFE);
      wr(IDFW_OFF_RDSEL, 32'd88);
      rdchk(IDFW_OFF_RDATA, 32'h0000007F);
      do_reset();
      chk("abort", 32'h0, {31'h0, abort});
      rdchk(IDFW_OFF_SECCFG, IDFW_SECCFG_RST);
      summarize();
   end
endmodule : tb_identify_feature_words
`default_nettype wire
